// file: rtl/tss_defines.vh
// constants of the trigger strobe sequencer: offsets, fields, resets, timing
`ifndef TSS_DEFINES_VH
`define TSS_DEFINES_VH

// clock and tick timing
`define TSS_CLK_NS          50
`define TSS_TICK_DOC_NS     15
`define TSS_STRB_MIN_NS     1000
`define TSS_STRB_MAX_NS     1000000000
`define TSS_STRB_MIN_CYC    ((`TSS_STRB_MIN_NS + `TSS_CLK_NS - 1) / `TSS_CLK_NS)
`define TSS_STRB_MAX_CYC    (`TSS_STRB_MAX_NS / `TSS_CLK_NS)

// register byte offsets
`define TSS_OFS_CTRL        12'h000
`define TSS_OFS_LOGIC       12'h004
`define TSS_OFS_EXPDLY      12'h008
`define TSS_OFS_STRDLY      12'h00C
`define TSS_OFS_STRDUR      12'h010
`define TSS_OFS_ROUTE       12'h014
`define TSS_OFS_STATUS      12'h018
`define TSS_OFS_NVSAVE      12'h01C
`define TSS_TBL_PAGE        2'h1

// control register fields
`define TSS_CTRL_SEQEN      0
`define TSS_CTRL_POL        1
`define TSS_CTRL_LAST_LO    4
`define TSS_CTRL_TEN        8
`define TSS_CTRL_TSRC_LO    9

// interval table fields, one word each
`define TSS_NUM_INT         16
`define TSS_NUM_FLD         10
`define TSS_F_INT           4'd0
`define TSS_F_ASTART        4'd1
`define TSS_F_ASTOP         4'd2
`define TSS_F_BSTART        4'd3
`define TSS_F_BSTOP         4'd4
`define TSS_F_PWMPER        4'd5
`define TSS_F_PWMON0        4'd6

// combiner operation codes
`define TSS_OP_AND          3'h0
`define TSS_OP_NAND         3'h1
`define TSS_OP_OR           3'h2
`define TSS_OP_NOR          3'h3
`define TSS_OP_XOR          3'h4
`define TSS_OP_XNOR         3'h5

// output line sources
`define TSS_RT_OFF          3'h0
`define TSS_RT_PULSEA       3'h1
`define TSS_RT_PULSEB       3'h2
`define TSS_RT_PWM          3'h3
`define TSS_RT_LOG1         3'h4
`define TSS_RT_LOG2         3'h5

// reset values
`define TSS_RST_WORD        32'h0000_0000

`endif

// file: rtl/tss_logic.v
// two-operand boolean combiner stage
`timescale 1ns/1ps
`include "tss_defines.vh"

module tss_logic (
    first_logic_operand,
    second_logic_operand,
    op,
    result
);
    input  wire       first_logic_operand;
    input  wire       second_logic_operand;
    input  wire [2:0] op;
    output reg        result;

    // standard truth tables; unused codes give a quiet low
    always @* begin
        case (op)
            `TSS_OP_AND:  result = first_logic_operand & second_logic_operand;  // R15
            `TSS_OP_NAND: result = ~(first_logic_operand & second_logic_operand);
            `TSS_OP_OR:   result = first_logic_operand | second_logic_operand;
            `TSS_OP_NOR:  result = ~(first_logic_operand | second_logic_operand);
            `TSS_OP_XOR:  result = first_logic_operand ^ second_logic_operand;
            `TSS_OP_XNOR: result = ~(first_logic_operand ^ second_logic_operand);
            default:      result = 1'b0;
        endcase
    end
endmodule // tss_logic

// file: rtl/tss_pwm.v
// four-channel pwm with shared base period
`timescale 1ns/1ps

module tss_pwm (
    clk,
    srst,
    run,
    restart,
    period,
    on0,
    on1,
    on2,
    on3,
    pwm
);
    input  wire        clk;
    input  wire        srst;
    input  wire        run;
    input  wire        restart;
    input  wire [31:0] period;
    input  wire [31:0] on0;
    input  wire [31:0] on1;
    input  wire [31:0] on2;
    input  wire [31:0] on3;
    output reg  [3:0]  pwm;

    reg  [31:0] cnt_q;
    reg  [31:0] cnt_d;
    wire [31:0] per_m1;

    // a zero period behaves as one tick so the counter never stalls
    assign per_m1 = (period == 32'h0000_0000) ? 32'h0000_0000 : period - 32'h0000_0001;

    always @* begin
        if (restart || !run || cnt_q >= per_m1) begin
            cnt_d = 32'h0000_0000;
        end else begin
            cnt_d = cnt_q + 32'h0000_0001;
        end
    end

    // counter restarts with each interval so periods line up with it
    always @(posedge clk) begin
        if (srst) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // decoded from the live count so an interval's first tick uses its own
    // on-times and nothing lingers once the sequencer stops
    always @* begin
        pwm[0] = run && (cnt_q < on0);  // R18
        pwm[1] = run && (cnt_q < on1);
        pwm[2] = run && (cnt_q < on2);
        pwm[3] = run && (cnt_q < on3);
    end
endmodule // tss_pwm

// file: rtl/tss_top.v
// trigger strobe sequencer: apb registers, trigger path, sequencer, routing
`timescale 1ns/1ps
`include "tss_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1: all times counted in clock ticks
// R2: exposure sequence starts programmed ticks after trigger
// R3: strobe output polarity selectable high or low
// R4: strobe duration clamped between 1 us and 1 s
// R5: strobe asserted programmed delay after trigger edge
// R6: interval duration, exposure start/stop per interval
// R7: strobe start/stop offsets per interval
// R8: per-interval pwm period and channel on-times
// R9: trigger runs through all programmed intervals
// R10: up to sixteen intervals, each own settings
// R11: software keeps exposure window inside interval
// R12: configuration save request to nonvolatile store
// R13: pulse A and pulse B routable to outputs
// R14: pwm channel n routable to output n
// R15: combiner does AND NAND OR NOR XOR XNOR
// R16: trigger-enable mode uses enable as second operand
// R17: logic result feeds trigger, next stage, output
// R18: pwm high for on-time at period start
// R19: intervals follow back to back, then idle
module tss_top #(
    parameter [31:0] STRB_MAX_CYC = `TSS_STRB_MAX_CYC
) (
    clk,
    srst,
    paddr,
    psel,
    penable,
    pwrite,
    pwdata,
    prdata,
    pready,
    pslverr,
    in_line,
    nv_save_ack,
    out_line,
    nv_save_req,
    seq_busy
);
    input  wire        clk;
    input  wire        srst;
    input  wire [11:0] paddr;
    input  wire        psel;
    input  wire        penable;
    input  wire        pwrite;
    input  wire [31:0] pwdata;
    output reg  [31:0] prdata;
    output wire        pready;
    output wire        pslverr;
    input  wire [3:0]  in_line;
    input  wire        nv_save_ack;
    output reg  [3:0]  out_line;
    output wire        nv_save_req;
    output wire        seq_busy;

    localparam [31:0] STRB_MIN_CYC = `TSS_STRB_MIN_CYC;
    localparam [1:0]  SQ_IDLE      = 2'b01;
    localparam [1:0]  SQ_RUN       = 2'b10;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // window test used by both pulses and the strobe shot
    function in_win;
        input [31:0] cnt;
        input [31:0] lo;
        input [31:0] hi;
        begin
            in_win = (cnt >= lo) && (cnt < hi);
        end
    endfunction

    // flat table index from interval and field
    function [7:0] tbl_ix;
        input [3:0] idx;
        input [3:0] fld;
        begin
            tbl_ix = idx * 8'd10 + {4'h0, fld};
        end
    endfunction

    // operand pick: three input lines or the stage before
    function pick;
        input [1:0] sel;
        input [3:0] lines;
        input       prev;
        begin
            pick = (sel == 2'd3) ? prev : lines[sel];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers

    reg  [31:0] ctrl_q;
    reg  [31:0] logic_q;
    reg  [31:0] expdly_q;
    reg  [31:0] strdly_q;
    reg  [31:0] strdur_q;
    reg  [31:0] route_q;
    reg         save_q;
    reg  [31:0] tbl_q [0:159];
    reg  [31:0] rd_d;
    reg         err_d;
    wire        setup;
    wire        wr_acc;
    wire        tbl_hit;
    wire [7:0]  wr_ix;
    wire [31:0] status;
    integer     i;

    reg  [1:0]  sq_state_q;
    reg  [3:0]  sq_idx_q;
    reg  [31:0] sq_cnt_q;
    reg         sh_run_q;
    reg  [31:0] sh_cnt_q;
    reg         trig_q;

    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite;
    assign tbl_hit = (paddr[11:10] == `TSS_TBL_PAGE) && (paddr[5:2] < 4'd10);
    assign wr_ix   = tbl_ix(paddr[9:6], paddr[5:2]);
    assign status  = {23'h0, save_q, sq_idx_q, 2'b00, sh_run_q, seq_busy};

    // zero wait states; read data was captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = err_d && psel && penable;

    // address decode for reads and error flag
    always @* begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (tbl_hit) begin
            rd_d = tbl_q[wr_ix];
        end else if (paddr == `TSS_OFS_CTRL) begin
            rd_d = ctrl_q;
        end else if (paddr == `TSS_OFS_LOGIC) begin
            rd_d = logic_q;
        end else if (paddr == `TSS_OFS_EXPDLY) begin
            rd_d = expdly_q;
        end else if (paddr == `TSS_OFS_STRDLY) begin
            rd_d = strdly_q;
        end else if (paddr == `TSS_OFS_STRDUR) begin
            rd_d = strdur_q;
        end else if (paddr == `TSS_OFS_ROUTE) begin
            rd_d = route_q;
        end else if (paddr == `TSS_OFS_STATUS) begin
            rd_d = status;
        end else if (paddr == `TSS_OFS_NVSAVE) begin
            rd_d = {31'h0, save_q};
        end else begin
            err_d = 1'b1;
        end
    end

    // register writes; status is read only, writes there are ignored
    always @(posedge clk) begin
        if (srst) begin
            ctrl_q   <= `TSS_RST_WORD;
            logic_q  <= `TSS_RST_WORD;
            expdly_q <= `TSS_RST_WORD;
            strdly_q <= `TSS_RST_WORD;
            strdur_q <= `TSS_RST_WORD;
            route_q  <= `TSS_RST_WORD;
            prdata   <= 32'h0000_0000;
            for (i = 0; i < 160; i = i + 1) begin
                tbl_q[i] <= `TSS_RST_WORD;  // R10
            end
        end else begin
            if (setup && !pwrite) begin
                prdata <= rd_d;
            end
            if (wr_acc) begin
                if (tbl_hit) begin
                    tbl_q[wr_ix] <= pwdata;  // R6
                end else if (paddr == `TSS_OFS_CTRL) begin
                    ctrl_q <= pwdata;
                end else if (paddr == `TSS_OFS_LOGIC) begin
                    logic_q <= pwdata;
                end else if (paddr == `TSS_OFS_EXPDLY) begin
                    expdly_q <= pwdata;
                end else if (paddr == `TSS_OFS_STRDLY) begin
                    strdly_q <= pwdata;
                end else if (paddr == `TSS_OFS_STRDUR) begin
                    strdur_q <= pwdata;
                end else if (paddr == `TSS_OFS_ROUTE) begin
                    route_q <= pwdata;
                end
            end
        end
    end

    // save request; a new request in the ack cycle wins over the clear
    always @(posedge clk) begin
        if (srst) begin
            save_q <= 1'b0;
        end else if (wr_acc && paddr == `TSS_OFS_NVSAVE && pwdata[0]) begin
            save_q <= 1'b1;  // R12
        end else if (nv_save_ack) begin
            save_q <= 1'b0;
        end
    end
    assign nv_save_req = save_q;

    ////////////////////////////////////////////////////////////////////////////
    // logic combiner, two chained stages

    wire a1;
    wire b1;
    wire a2;
    wire b2;
    wire log1;
    wire log2;
    wire trig_src;
    wire trig_edge;

    // trigger-enable mode swaps the second operand for the enable bit
    assign a1 = pick(logic_q[5:4], in_line, in_line[3]);
    assign b1 = logic_q[3] ? ctrl_q[`TSS_CTRL_TEN]
                           : pick(logic_q[7:6], in_line, in_line[3]);  // R16
    assign a2 = pick(logic_q[13:12], in_line, log1);  // R17
    assign b2 = logic_q[11] ? ctrl_q[`TSS_CTRL_TEN]
                            : pick(logic_q[15:14], in_line, log1);

    tss_logic u_log1 (
        .first_logic_operand  (a1),
        .second_logic_operand (b1),
        .op                   (logic_q[2:0]),
        .result               (log1)
    );

    tss_logic u_log2 (
        .first_logic_operand  (a2),
        .second_logic_operand (b2),
        .op                   (logic_q[10:8]),
        .result               (log2)
    );

    // trigger source: line 0, stage one or stage two result
    assign trig_src = (ctrl_q[10:9] == 2'd1) ? log1 :
                      (ctrl_q[10:9] == 2'd2) ? log2 : in_line[0];  // R17
    assign trig_edge = trig_src && !trig_q;

    ////////////////////////////////////////////////////////////////////////////
    // trigger shot: exposure delay and stand-alone strobe pulse

    wire [31:0] dur;
    wire [31:0] str_end;
    wire        shot_strobe;
    wire        seq_go;

    // duration outside the legal span is pulled to the nearest bound
    assign dur = (strdur_q < STRB_MIN_CYC) ? STRB_MIN_CYC :
                 (strdur_q > STRB_MAX_CYC) ? STRB_MAX_CYC : strdur_q;  // R4
    assign str_end     = strdly_q + dur;
    assign shot_strobe = sh_run_q && in_win(sh_cnt_q, strdly_q, str_end);  // R5
    assign seq_go      = sh_run_q && (sh_cnt_q == expdly_q);  // R2

    // a trigger edge during a running shot is ignored, not queued
    always @(posedge clk) begin
        if (srst) begin
            trig_q   <= 1'b0;
            sh_run_q <= 1'b0;
            sh_cnt_q <= 32'h0000_0000;
        end else begin
            trig_q <= trig_src;
            if (!sh_run_q) begin
                sh_cnt_q <= 32'h0000_0000;
                sh_run_q <= trig_edge;
            end else if (sh_cnt_q >= expdly_q && sh_cnt_q >= str_end) begin
                sh_run_q <= 1'b0;
            end else begin
                sh_cnt_q <= sh_cnt_q + 32'h0000_0001;  // R1
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    wire [31:0] int_len;
    wire [31:0] int_m1;
    wire        int_done;
    wire        last;
    wire        pulse_a;
    wire        pulse_b;
    wire        sq_run;
    wire        sq_start;

    assign sq_run   = sq_state_q[1];
    assign seq_busy = sq_run;
    assign int_len  = tbl_q[tbl_ix(sq_idx_q, `TSS_F_INT)];
    assign int_m1   = (int_len == 32'h0000_0000) ? 32'h0000_0000
                                                 : int_len - 32'h0000_0001;
    assign int_done = sq_cnt_q >= int_m1;
    assign last     = sq_idx_q == ctrl_q[`TSS_CTRL_LAST_LO+3:`TSS_CTRL_LAST_LO];
    assign sq_start = sq_state_q[0] && seq_go && ctrl_q[`TSS_CTRL_SEQEN];

    // window offsets count from each interval start
    assign pulse_a = sq_run && in_win(sq_cnt_q,
                     tbl_q[tbl_ix(sq_idx_q, `TSS_F_ASTART)],
                     tbl_q[tbl_ix(sq_idx_q, `TSS_F_ASTOP)]);  // R6
    assign pulse_b = sq_run && in_win(sq_cnt_q,
                     tbl_q[tbl_ix(sq_idx_q, `TSS_F_BSTART)],
                     tbl_q[tbl_ix(sq_idx_q, `TSS_F_BSTOP)]);  // R7

    // overlong windows are cut at the interval end by the counter wrap
    always @(posedge clk) begin
        if (srst) begin
            sq_state_q <= SQ_IDLE;
            sq_idx_q   <= 4'h0;
            sq_cnt_q   <= 32'h0000_0000;
        end else begin
            case (sq_state_q)
                SQ_IDLE: begin
                    sq_idx_q <= 4'h0;
                    sq_cnt_q <= 32'h0000_0000;
                    if (sq_start) begin
                        sq_state_q <= SQ_RUN;  // R9
                    end
                end
                SQ_RUN: begin
                    if (!int_done) begin
                        sq_cnt_q <= sq_cnt_q + 32'h0000_0001;
                    end else if (last) begin
                        sq_state_q <= SQ_IDLE;  // R19
                    end else begin
                        sq_cnt_q <= 32'h0000_0000;
                        sq_idx_q <= sq_idx_q + 4'h1;  // R19
                    end
                end
                default: begin
                    sq_state_q <= SQ_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pwm for the current interval

    wire [3:0] pwm;
    wire       pwm_restart;

    assign pwm_restart = sq_start || (sq_run && int_done);

    tss_pwm u_pwm (
        .clk     (clk),
        .srst    (srst),
        .run     (sq_run),
        .restart (pwm_restart),
        .period  (tbl_q[tbl_ix(sq_idx_q, `TSS_F_PWMPER)]),  // R8
        .on0     (tbl_q[tbl_ix(sq_idx_q, `TSS_F_PWMON0)]),
        .on1     (tbl_q[tbl_ix(sq_idx_q, `TSS_F_PWMON0 + 4'd1)]),
        .on2     (tbl_q[tbl_ix(sq_idx_q, `TSS_F_PWMON0 + 4'd2)]),
        .on3     (tbl_q[tbl_ix(sq_idx_q, `TSS_F_PWMON0 + 4'd3)]),
        .pwm     (pwm)
    );

    ////////////////////////////////////////////////////////////////////////////
    // output routing, three select bits per line

    wire strobe_lvl;
    reg  [3:0] out_d;
    reg  [2:0] rsel;
    integer    n;

    // polarity applies to the strobe only, not to the exposure pulse
    assign strobe_lvl = (shot_strobe | pulse_b) ^ ctrl_q[`TSS_CTRL_POL];  // R3

    always @* begin
        rsel  = 3'h0;
        out_d = 4'h0;
        for (n = 0; n < 4; n = n + 1) begin
            rsel = route_q[n*3 +: 3];
            case (rsel)
                `TSS_RT_PULSEA: out_d[n] = pulse_a;     // R13
                `TSS_RT_PULSEB: out_d[n] = strobe_lvl;  // R13
                `TSS_RT_PWM:    out_d[n] = pwm[n];      // R14
                `TSS_RT_LOG1:   out_d[n] = log1;        // R17
                `TSS_RT_LOG2:   out_d[n] = log2;
                default:        out_d[n] = 1'b0;
            endcase
        end
    end

    // registered so routing glitches never reach the pins
    always @(posedge clk) begin
        if (srst) begin
            out_line <= 4'h0;
        end else begin
            out_line <= out_d;
        end
    end
endmodule // tss_top

// file: test/tss_far.sv
// nonvolatile store model that answers save requests
`timescale 1ns/1ps
module tss_far #(
    parameter integer ACK_DLY = 6
) (
    input  wire  clk,
    input  wire  nv_save_req,
    output logic nv_save_ack = 1'b0
);
    integer wait_q = 0;
    ////////////////////////////////////////
    // write time is modelled as a fixed wait, then a one-cycle ack
    always @(posedge clk) begin
        nv_save_ack <= 1'b0;
        if (nv_save_req && !nv_save_ack) begin
            wait_q <= wait_q + 1;
            if (wait_q == ACK_DLY) begin
                nv_save_ack <= 1'b1;
                wait_q <= 0;
            end
        end
    end
endmodule // tss_far

// file: test/tss_top_monitor.sv
// apb and save handshake checker for the sequencer top
`timescale 1ns/1ps
module tss_mon #(
    parameter [31:0] STRB_MAX_CYC = 32'd200
) (
    input wire        clk,
    input wire        srst,
    input wire [11:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [3:0]  in_line,
    input wire        nv_save_ack,
    input wire [3:0]  out_line,
    input wire        nv_save_req,
    input wire        seq_busy
);
    ////////////////////////////////////////
    // decode kept apart from the design so a wrong map shows up
    wire mapped  = (paddr < 12'h020) || (paddr[11:10] == 2'h1 && paddr[5:2] < 4'hA);
    wire save_wr = pwrite && paddr == 12'h01C && pwdata[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    ////////////////////////////////////////
    a_ready_high: assert property (s_access |-> pready)
        else $error("pready low in access");
    a_err_decode: assert property (s_access ##0 (paddr[1:0] == 2'h0) |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access");
    a_err_rd_zero: assert property (s_access ##0 (!pwrite && pslverr) |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rd_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without read");
    a_save_set: assert property (s_setup ##1 (s_access and save_wr) |=> nv_save_req)
        else $error("save request not raised");
    a_save_hold: assert property (nv_save_req && !nv_save_ack |=> nv_save_req)
        else $error("save request dropped early");
    a_save_clear: assert property (nv_save_ack && !(psel && penable && save_wr) |=> !nv_save_req)
        else $error("save request not cleared");
    a_rst_quiet: assert property ($fell(srst) |-> out_line == 4'h0 && !seq_busy && !nv_save_req
        && prdata == 32'h0)
        else $error("outputs not idle after reset");
endmodule // tss_mon
bind tss_top tss_mon #(.STRB_MAX_CYC(STRB_MAX_CYC)) u_mon (.clk(clk), .srst(srst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_line(in_line),
    .nv_save_ack(nv_save_ack), .out_line(out_line), .nv_save_req(nv_save_req),
    .seq_busy(seq_busy));

// file: test/tss_top_tb.sv
// self-checking bench for the trigger strobe sequencer
`timescale 1ns/1ps
module tss_top_tb;
    logic        clk;
    logic        srst;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    logic [3:0]  in_line;
    wire         nv_save_ack;
    wire  [3:0]  out_line;
    wire         nv_save_req;
    wire         seq_busy;
    integer      failures;
    integer      check_count;
    logic [31:0] q;
    logic        err_q;
    integer      b1, s1, b2, s2, op, v, i;
    tss_top #(.STRB_MAX_CYC(32'd200)) u_dut (.clk(clk), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .in_line(in_line), .nv_save_ack(nv_save_ack),
        .out_line(out_line), .nv_save_req(nv_save_req), .seq_busy(seq_busy));
    tss_far u_far (.clk(clk), .nv_save_req(nv_save_req), .nv_save_ack(nv_save_ack));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one apb transfer, driven and sampled on rising edges only
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n = n + 1;
        end
        q = prdata;
        err_q = pslverr;
        if (pready !== 1'b1) failures = failures + 1;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    function automatic logic lop(input integer o, input logic a, input logic b);
        case (o)
            0: lop = a & b;
            1: lop = ~(a & b);
            2: lop = a | b;
            3: lop = ~(a | b);
            4: lop = a ^ b;
            default: lop = ~(a ^ b);
        endcase
    endfunction
    // fire the trigger and count busy, pulse, strobe and pwm cycles
    task automatic shot(input logic pol, input integer ens, output integer tb_,
                        output integer ts);
        integer k, nb, na, ns, np;
        nb = 0;
        na = 0;
        ns = 0;
        np = 0;
        tb_ = -1;
        ts = -1;
        @(posedge clk);
        in_line <= 4'h1;
        for (k = 1; k <= 100; k = k + 1) begin
            @(negedge clk);
            if (seq_busy === 1'b1) nb = nb + 1;
            if (seq_busy === 1'b1 && tb_ < 0) tb_ = k;
            if (out_line[1] !== pol) ns = ns + 1;
            if (out_line[1] !== pol && ts < 0) ts = k;
            if (out_line[0] === 1'b1) na = na + 1;
            if (out_line[2] === 1'b1) np = np + 1;
        end
        @(posedge clk);
        in_line <= 4'h0;
        chk(nb, 40);
        chk(na, 7);
        chk(ns, ens);
        chk(np, 13);
        chk(seq_busy, 1'b0);
    endtask
    ////////////////////////////////////////
    // clock and a watchdog far beyond the several hundred cycles needed
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures = failures + 1;
        tally_and_finish;
    end
    ////////////////////////////////////////
    initial begin
        failures = 0;
        check_count = 0;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        in_line = 4'h0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        apb(0, 12'h018, 0);
        chk(q, 32'h0);
        apb(0, 12'h020, 0);
        chk(q, 32'h0);
        chk(err_q, 1'b1);
        apb(0, 12'h428, 0);
        chk(err_q, 1'b1);
        apb(1, 12'h7E4, 32'h0000_ABCD);
        apb(0, 12'h7E4, 0);
        chk(q, 32'h0000_ABCD);
        apb(1, 12'h010, 32'h3);
        apb(0, 12'h010, 0);
        chk(q, 32'd3);
        apb(1, 12'h010, 32'd1000);
        apb(0, 12'h010, 0);
        chk(q, 32'd1000);
        // logic stage one on lines 0/1, stage two ors it with line 2
        apb(1, 12'h014, 32'h2C);
        for (op = 0; op < 6; op = op + 1) begin
            apb(1, 12'h004, {16'h0, 8'hB2, 5'h08, op[2:0]});
            for (v = 0; v < 8; v = v + 1) begin
                @(posedge clk);
                in_line <= v[3:0];
                settle;
                chk(out_line[0], lop(op, v[0], v[1]));
                chk(out_line[1], lop(op, v[0], v[1]) | v[2]);
            end
        end
        // enable mode: line 1 is high yet only the enable bit may pass
        apb(1, 12'h004, 32'h48);
        in_line <= 4'h3;
        for (v = 0; v < 2; v = v + 1) begin
            apb(1, 12'h000, {23'h0, v[0], 8'h0});
            settle;
            chk(out_line[0], v[0]);
        end
        @(posedge clk);
        in_line <= 4'h0;
        // two intervals of 20 ticks with their own pulse and pwm settings
        for (i = 0; i < 2; i = i + 1) begin
            apb(1, 12'h400 + i * 64, 32'd20);
            apb(1, 12'h404 + i * 64, i ? 32'd0 : 32'd2);
            apb(1, 12'h408 + i * 64, i ? 32'd3 : 32'd6);
            apb(1, 12'h40C + i * 64, 32'd10 * i);
            apb(1, 12'h410 + i * 64, 32'd12 * i);
            apb(1, 12'h414 + i * 64, 32'd4 + i);
            apb(1, 12'h420 + i * 64, 32'd1 + i);
        end
        apb(0, 12'h454, 0);
        chk(q, 32'd5);
        apb(1, 12'h014, 32'hD1);
        apb(1, 12'h010, 32'd25);
        apb(1, 12'h000, 32'h111);
        shot(1'b0, 27, b1, s1);
        settle;
        apb(1, 12'h008, 32'd4);
        apb(1, 12'h00C, 32'd3);
        apb(1, 12'h010, 32'd3);
        apb(1, 12'h000, 32'h113);
        settle;
        shot(1'b1, 22, b2, s2);
        chk(b2 - b1, 4);
        chk(s2 - s1, 3);
        // save request stays up until the store acknowledges
        apb(1, 12'h01C, 32'h1);
        chk(nv_save_req, 1'b1);
        for (i = 0; i < 30 && nv_save_req !== 1'b0; i = i + 1) @(negedge clk);
        chk(nv_save_req, 1'b0);
        tally_and_finish;
    end
endmodule // tss_top_tb
